// [djkff_dual_flip_flop.sv]
// Dual J-K storage element with asynchronous-style set and reset overrides
// All pins are foreign to ref_clk and pass a two-stage synchroniser. The
// element clock is edge-detected after the second stage, so data and clock
// share one pipeline and are seen in the same ref_clk cycle.
//
// Latency: a pin change sampled at ref_clk edge N reaches q and q_n at
// edge N+2, three edges after the change when the sampling edge counts.
// Overrides take the same path, so their effect has that fixed delay.
//
// Element clock pulses, high or low, shorter than one ref_clk period may
// be missed. Data must stand two periods before and one after a fall.
//
// Overrides win over any clock edge. A fall seen while an override is low
// is discarded, and releasing an override never creates an edge.
//
// With both overrides low the stored level becomes high and both pins read
// high. Once both are released the outputs are complementary again, q high.
// Releasing one before the other leaves the remaining override in charge.
`include "djkff_consts.svh"

module djkff_dual_flip_flop
  import djkff_pkg::*;
(
  // System clock and synchronous reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Element clocks, one bit per element
  input  wire logic [1:0] jk_clk,
  // Data inputs, one bit per element
  input  wire logic [1:0] set_request,
  input  wire logic [1:0] reset_request,
  // Overrides, active low, one bit per element
  input  wire logic [1:0] async_set_n,
  input  wire logic [1:0] async_reset_n,
  // Complementary outputs, one bit per element
  output logic      [1:0] q,
  output logic      [1:0] q_n
);

  // Decode the data pair into the action of a falling clock edge
  // Set request is the upper bit, reset request the lower one
  // All four codes are legal, so no default is needed
  function automatic djkff_action_t djkff_decode(input logic set_in, input logic rst_in);
    djkff_action_t act;
    act = DJKFF_HOLD;
    unique case ({set_in, rst_in})
      2'h0: act = DJKFF_HOLD;
      2'h2: act = DJKFF_SET;
      2'h1: act = DJKFF_RESET;
      2'h3: act = DJKFF_TOGGLE;
    endcase
    return act;
  endfunction : djkff_decode

  // Decode the override pair of one element
  // Both inputs are active low: all ones means no override at all
  // All four codes are legal, so no default is needed
  function automatic djkff_ovr_t djkff_ovr(input logic set_n_in, input logic rst_n_in);
    djkff_ovr_t ovr;
    ovr = DJKFF_OVR_NONE;
    unique case ({set_n_in, rst_n_in})
      2'h3: ovr = DJKFF_OVR_NONE;
      2'h1: ovr = DJKFF_OVR_SET;
      2'h2: ovr = DJKFF_OVR_RESET;
      2'h0: ovr = DJKFF_OVR_BOTH;
    endcase
    return ovr;
  endfunction : djkff_ovr

  // Synchroniser stages: stage 1 feeds only stage 2
  logic [1:0] clk_s1_q,  clk_s2_q,  clk_prev_q;
  logic [1:0] set_s1_q,  set_s2_q;
  logic [1:0] rst_s1_q,  rst_s2_q;
  logic [1:0] ovs_s1_q,  ovs_s2_q;
  logic [1:0] ovr_s1_q,  ovr_s2_q;
  logic [1:0] clk_prev_d;

  // Next values of the synchroniser stages
  logic [1:0] clk_s1_d,  clk_s2_d;
  logic [1:0] set_s1_d,  set_s2_d;
  logic [1:0] rst_s1_d,  rst_s2_d;
  logic [1:0] ovs_s1_d,  ovs_s2_d;
  logic [1:0] ovr_s1_d,  ovr_s2_d;

  // Storage state
  // The q register is the stored level; qn_q follows it except when
  // both overrides are low and both pins must read high together
  logic [1:0] q_q,  q_d;
  logic [1:0] qn_q, qn_d;
  logic [1:0] fall;

  // Shift each pin one stage further along its synchroniser
  always_comb begin
    // Element clocks
    clk_s1_d = jk_clk;
    clk_s2_d = clk_s1_q;
    // Data inputs
    set_s1_d = set_request;
    set_s2_d = set_s1_q;
    rst_s1_d = reset_request;
    rst_s2_d = rst_s1_q;
    // Overrides
    ovs_s1_d = async_set_n;
    ovs_s2_d = ovs_s1_q;
    ovr_s1_d = async_reset_n;
    ovr_s2_d = ovr_s1_q;
  end

  // Two-flop synchronisers on every pin, plus the edge history flop
  // Overrides reset to their inactive level so reset forces nothing
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      // Clock low at reset: a pin already low gives no false edge
      clk_s1_q   <= {2{`DJKFF_CLK_SYNC_RST}};
      clk_s2_q   <= {2{`DJKFF_CLK_SYNC_RST}};
      clk_prev_q <= {2{`DJKFF_CLK_SYNC_RST}};
      // Data inputs
      set_s1_q   <= {2{`DJKFF_DATA_SYNC_RST}};
      set_s2_q   <= {2{`DJKFF_DATA_SYNC_RST}};
      rst_s1_q   <= {2{`DJKFF_DATA_SYNC_RST}};
      rst_s2_q   <= {2{`DJKFF_DATA_SYNC_RST}};
      // Overrides
      ovs_s1_q   <= {2{`DJKFF_OVR_IDLE}};
      ovs_s2_q   <= {2{`DJKFF_OVR_IDLE}};
      ovr_s1_q   <= {2{`DJKFF_OVR_IDLE}};
      ovr_s2_q   <= {2{`DJKFF_OVR_IDLE}};
    end else begin
      // Element clocks
      clk_s1_q   <= clk_s1_d;
      clk_s2_q   <= clk_s2_d;
      clk_prev_q <= clk_prev_d;
      // Data inputs
      set_s1_q   <= set_s1_d;
      set_s2_q   <= set_s2_d;
      rst_s1_q   <= rst_s1_d;
      rst_s2_q   <= rst_s2_d;
      // Overrides
      ovs_s1_q   <= ovs_s1_d;
      ovs_s2_q   <= ovs_s2_d;
      ovr_s1_q   <= ovr_s1_d;
      ovr_s2_q   <= ovr_s2_d;
    end
  end

  // Falling edge seen on the synchronised element clock
  always_comb begin
    clk_prev_d = clk_s2_q;
    fall       = clk_prev_q & ~clk_s2_q;
  end

  // Next output levels, element by element
  // Override decode comes first, so any low override hides the clock
  // and the data inputs of that element for as long as it stays low
  always_comb begin
    q_d  = q_q;
    qn_d = qn_q;
    for (int i = 0; i < `DJKFF_NUM_ELEM; i++) begin
      unique case (djkff_ovr(ovs_s2_q[i], ovr_s2_q[i]))
        DJKFF_OVR_SET: begin
          q_d[i]  = 1'h1;
          qn_d[i] = 1'h0;
        end
        DJKFF_OVR_RESET: begin
          q_d[i]  = 1'h0;
          qn_d[i] = 1'h1;
        end
        DJKFF_OVR_BOTH: begin
          // Stored level becomes high and both pins show high-high
          q_d[i]  = 1'h1;
          qn_d[i] = 1'h1;
        end
        DJKFF_OVR_NONE: begin
          // Leaving high-high returns to complementary levels at once
          qn_d[i] = ~q_q[i];
          if (fall[i]) begin
            unique case (djkff_decode(set_s2_q[i], rst_s2_q[i]))
              DJKFF_HOLD:   q_d[i] = q_q[i];
              DJKFF_SET:    q_d[i] = 1'h1;
              DJKFF_RESET:  q_d[i] = 1'h0;
              DJKFF_TOGGLE: q_d[i] = ~q_q[i];
            endcase
            qn_d[i] = ~q_d[i];
          end
        end
      endcase
    end
  end

  // Output registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q_q  <= {2{`DJKFF_Q_RST}};
      qn_q <= {2{~`DJKFF_Q_RST}};
    end else begin
      q_q  <= q_d;
      qn_q <= qn_d;
    end
  end

  // Outputs straight from flip-flops
  // No logic sits between the registers and the pins
  always_comb begin
    q   = q_q;
    q_n = qn_q;
  end

endmodule : djkff_dual_flip_flop

// [djkff_consts.svh]
// Constants for the dual J-K storage block
`ifndef DJKFF_CONSTS_SVH
`define DJKFF_CONSTS_SVH

// Number of independent storage elements
`define DJKFF_NUM_ELEM       2
// Stored level after reset_n
`define DJKFF_Q_RST          1'h0
// Reset level of the element clock synchroniser
`define DJKFF_CLK_SYNC_RST   1'h0
// Reset level of data input synchronisers
`define DJKFF_DATA_SYNC_RST  1'h0
// Inactive level of the override synchronisers
`define DJKFF_OVR_IDLE       1'h1

`endif

// [djkff_pkg.sv]
// Types shared by the dual J-K storage block
package djkff_pkg;

  // Action taken by one element at a falling edge of its clock
  typedef enum logic [1:0] {
    DJKFF_HOLD,
    DJKFF_SET,
    DJKFF_RESET,
    DJKFF_TOGGLE
  } djkff_action_t;

  // Which override pattern is active on one element
  typedef enum logic [1:0] {
    DJKFF_OVR_NONE,
    DJKFF_OVR_SET,
    DJKFF_OVR_RESET,
    DJKFF_OVR_BOTH
  } djkff_ovr_t;

endpackage : djkff_pkg

// [djkff_drv.sv]
// Model of the logic that drives the element clocks
module djkff_drv (
  // Clock and command
  input  wire logic       ref_clk,
  input  wire logic       go,
  // Element clocks
  output logic      [1:0] jk_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial jk_clk = 2'h0;
  // One pulse on both clocks, high 3 cycles, falls well after data settle
  always @(posedge ref_clk) if (go) begin
    #1 jk_clk = 2'h3;
    repeat (3) @(posedge ref_clk);
    #1 jk_clk = 2'h0;
  end
endmodule : djkff_drv

// [djkff_chk.sv]
// Checker for the dual J-K block
module djkff_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // Pins
  input wire logic [1:0] jk_clk,
  input wire logic [1:0] set_request,
  input wire logic [1:0] reset_request,
  input wire logic [1:0] async_set_n,
  input wire logic [1:0] async_reset_n,
  input wire logic [1:0] q,
  input wire logic [1:0] q_n
);
  logic [3:0] rst_q;
  logic [1:0] idle;
  // Keeps checks off until the input pipeline holds post-reset values
  always_ff @(posedge ref_clk) begin
    if (!reset_n) rst_q <= 4'h0;
    else rst_q <= {rst_q[2:0], 1'h1};
  end
  assign idle = async_set_n & async_reset_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n || rst_q != 4'hF);
  // Recognised falling edge with given data, overrides idle
  sequence fall_s(int i, bit j, bit k);
    $past(jk_clk[i], 4) && !$past(jk_clk[i], 3) && $past(idle[i], 3)
      && $past(set_request[i], 3) == j && $past(reset_request[i], 3) == k;
  endsequence
  set_a: assert property (fall_s(0, 1, 0) |-> q[0] && !q_n[0]) else $error("no set");
  reset_a: assert property (fall_s(1, 0, 1) |-> !q[1] && q_n[1]) else $error("no reset");
  hold_a: assert property (fall_s(0, 0, 0) |-> $stable(q[0])) else $error("no hold");
  toggle_a: assert property (fall_s(1, 1, 1) |-> $changed(q[1])) else $error("no toggle");
  still_a: assert property ($past(idle[0], 4) && $past(idle[0], 3)
    && !(!$past(jk_clk[0], 3) && $past(jk_clk[0], 4)) |-> $stable(q[0])) else $error("moved");
  pset_a: assert property (!$past(async_set_n[0], 3) && $past(async_reset_n[0], 3)
    |-> q[0] && !q_n[0]) else $error("no force set");
  prst_a: assert property ($past(async_set_n[1], 3) && !$past(async_reset_n[1], 3)
    |-> !q[1] && q_n[1]) else $error("no force reset");
  both_a: assert property (!$past(async_reset_n[0], 3) && !$past(async_set_n[0], 3)
    |-> q[0] && q_n[0]) else $error("both low");
  compl_a: assert property ($past(async_set_n[1], 3) || $past(async_reset_n[1], 3)
    |-> q_n[1] == !q[1]) else $error("not complementary");
endmodule : djkff_chk

bind djkff_dual_flip_flop djkff_chk i_chk (.*);

// [djkff_dual_flip_flop_test.sv]
// Testbench of the dual J-K block
module djkff_dual_flip_flop_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'h0, reset_n = 1'h0, go = 1'h0;
  logic [1:0] jk_clk, q, q_n, set_request = 2'h0, reset_request = 2'h0;
  logic [1:0] async_set_n = 2'h3, async_reset_n = 2'h3;
  int         fails = 0, num_checks = 0, cyc = 0;
  // Rows: set_request, reset_request, expected q
  logic [5:0] rows [8] = '{6'h19, 6'h01, 6'h3E, 6'h3D, 6'h26, 6'h3D, 6'h01, 6'h26};
  djkff_drv i_drv (.*);
  djkff_dual_flip_flop i_dut (.*);
  always #4 ref_clk = ~ref_clk;
  // Cycle ceiling against a hang
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 500) begin
      fails++;
      end_of_test();
    end
  end
  task wt(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  task fall();
    go = 1'h1;
    wt(1);
    go = 1'h0;
    wt(9);
  endtask : fall
  task chk(string n, logic [1:0] e, logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task end_of_test();
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    wt(4);
    reset_n = 1'h1;
    chk("q_n", 2'h3, q_n);
    foreach (rows[i]) begin
      {set_request, reset_request} = rows[i][5:2];
      fall();
      chk("q", rows[i][1:0], q);
      chk("q_n", ~rows[i][1:0], q_n);
    end
    {async_set_n, async_reset_n} = 4'h9;
    fall();
    chk("q", 2'h1, q);
    chk("q_n", 2'h2, q_n);
    async_reset_n = 2'h0;
    wt(4);
    chk("q_n", 2'h3, q_n);
    async_set_n = 2'h3;
    wt(4);
    async_reset_n = 2'h3;
    wt(4);
    chk("q", 2'h0, q);
    {set_request, reset_request} = 4'hF;
    fall();
    chk("q", 2'h3, q);
    reset_n = 1'h0;
    wt(2);
    chk("q", 2'h0, q);
    chk("q_n", 2'h3, q_n);
    reset_n = 1'h1;
    fall();
    chk("q", 2'h3, q);
    end_of_test();
  end
endmodule : djkff_dual_flip_flop_test
